// ==== sfpe_defs.svh ====
// Constants for the serial flash program/erase sequencer: opcodes, widths,
// clock rate and default operation times. Included by the sequencer and the checker.
// Behaviour
// [R1] Opcodes 84H/87H load buffer at 10-bit offset
// [R2] Data bytes fill successive offsets, wrapping, until deselect
// [R3] Opcodes 83H/86H program page with erase
// [R4] Deselect erases then programs page; busy meanwhile
// [R5] Opcodes 88H/89H program only; busy program time
// [R6] Host erases target page before program-only
// [R7] Opcode 81H erases one page; busy erase time
// [R8] Opcode 50H erases eight-page block; busy block time
// [R9] Block number is page bits 12 to 3
// [R10] Opcodes 82H/85H load buffer then program page
// [R11] Deselect after load erases and programs page
// [R12] Opcodes 53H/55H copy page into buffer
// [R13] Host keeps select low while clocking command
// [R14] Opcodes 58H/59H rewrite page through chosen buffer
// [R15] Rewrite copies page, then erases and reprograms
// [R16] Status bit 7 high when idle, low busy
// [R17] All bytes shifted most significant bit first
// [R18] Deselect before full address abandons the command
`ifndef SFPE_DEFS_SVH
`define SFPE_DEFS_SVH

`define SFPE_OP_LOAD_B1 8'h84
`define SFPE_OP_LOAD_B2 8'h87
`define SFPE_OP_PGE_B1 8'h83
`define SFPE_OP_PGE_B2 8'h86
`define SFPE_OP_PGN_B1 8'h88
`define SFPE_OP_PGN_B2 8'h89
`define SFPE_OP_PERASE 8'h81
`define SFPE_OP_BERASE 8'h50
`define SFPE_OP_THRU_B1 8'h82
`define SFPE_OP_THRU_B2 8'h85
`define SFPE_OP_XFR_B1 8'h53
`define SFPE_OP_XFR_B2 8'h55
`define SFPE_OP_ARW_B1 8'h58
`define SFPE_OP_ARW_B2 8'h59

// Address field positions within the 24-bit address
`define SFPE_PAGE_MSB 22
`define SFPE_PAGE_LSB 10
`define SFPE_OFFS_MSB 9
`define SFPE_BLK_LSB 3
// Buffer holds 528 bytes; last offset before wrap
`define SFPE_BUF_LAST 10'h20F
// Byte index at which the first data byte arrives
`define SFPE_DATA_IDX 3'h4
// Core clock rate in MHz
`define SFPE_CLK_MHZ 20
// Default operation times in microseconds
`define SFPE_EP_US 20000
`define SFPE_P_US 14000
`define SFPE_PE_US 8000
`define SFPE_BE_US 12000
`define SFPE_XFR_US 300
// Status byte ready bit position
`define SFPE_ST_RDY 7

`endif

// ==== sfpe_pkg.sv ====
// Types for the serial flash program/erase sequencer.
// Assumes nothing of its surroundings.
package sfpe_pkg;
	// Sequencer states, one-hot
	typedef enum logic [1:0] {
		SFPE_ST_IDLE = 2'b01,
		SFPE_ST_BUSY = 2'b10
	} sfpe_state_t;

	// Kind of self-timed array operation
	typedef enum logic [2:0] {
		SFPE_K_NONE = 3'h0,
		SFPE_K_PGM_ERASE = 3'h1,
		SFPE_K_PGM_ONLY = 3'h2,
		SFPE_K_PAGE_ERASE = 3'h3,
		SFPE_K_BLOCK_ERASE = 3'h4,
		SFPE_K_COPY = 3'h5,
		SFPE_K_REWRITE = 3'h6
	} sfpe_kind_t;
endpackage : sfpe_pkg

// ==== sfpe_seq.sv ====
// Serial flash program/erase command sequencer with two page buffers.
// Assumes sck_i is the host's serial clock, idle outside frames, and that
// cs_n_i, si_i change on the falling sck edge (mode 0/3 style sampling).
`include "sfpe_defs.svh"

module sfpe_seq #(
	parameter int EP_US = `SFPE_EP_US,
	parameter int P_US = `SFPE_P_US,
	parameter int PE_US = `SFPE_PE_US,
	parameter int BE_US = `SFPE_BE_US,
	parameter int XFR_US = `SFPE_XFR_US
) (
	// Core clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Serial link pins
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	// Ready/busy and status
	output logic rdy_o,
	output logic [7:0] status_o,
	// Array operation report
	output logic op_start_o,
	output sfpe_pkg::sfpe_kind_t op_kind_o,
	output logic op_buf_o,
	output logic [12:0] op_page_o,
	output logic [9:0] op_block_o,
	// Buffer read port for the array side
	input wire logic rd_en_i,
	input wire logic rd_buf_i,
	input wire logic [9:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	// Byte lost because the receive buffer was full
	output logic ovf_o
);
	import sfpe_pkg::*;

	// Cycle counts derived from the times; exact products, nothing rounds
	localparam int EP_CYC = EP_US * `SFPE_CLK_MHZ;
	localparam int P_CYC = P_US * `SFPE_CLK_MHZ;
	localparam int PE_CYC = PE_US * `SFPE_CLK_MHZ;
	localparam int BE_CYC = BE_US * `SFPE_CLK_MHZ;
	localparam int XFR_CYC = XFR_US * `SFPE_CLK_MHZ;

	// Link-side state that lives across frames
	typedef struct packed {
		logic tog;        // Flips once per received byte
		logic [8:0] word; // First-of-frame flag and byte
		logic [6:0] shf;  // Bits gathered so far
	} sfpe_lnk_t;

	// Link-side state that restarts with each frame
	typedef struct packed {
		logic [2:0] bits; // Bit position in the current byte
		logic first;      // Next byte is the opcode
	} sfpe_frm_t;

	// Core-side state
	typedef struct packed {
		logic cs_s1;           // Select synchroniser, first stage
		logic cs_s2;           // Select synchroniser, second stage
		logic cs_d;            // Delayed for edge detect
		logic tg_s1;           // Byte toggle synchroniser
		logic tg_s2;
		logic tg_d;
		logic [1:0][8:0] fifo; // Two-entry receive buffer
		logic [1:0] wp;        // Fill pointer, one wrap bit
		logic [1:0] rp;        // Drain pointer
		logic end_pend;        // Deselect seen, waiting for buffer to drain
		sfpe_state_t st;
		logic [7:0] opc;       // Opcode of the frame
		logic [2:0] idx;       // Byte index within frame, saturates
		logic [23:0] addr;     // Address bytes
		logic [9:0] offs;      // Running buffer offset
		logic [31:0] cnt;      // Busy countdown
		logic start;
		sfpe_kind_t kind;
		logic bsel;
		logic [12:0] page;
		logic [9:0] blk;
		logic ovf;
	} sfpe_core_t;

	sfpe_lnk_t lnk_r;
	sfpe_lnk_t lnk_nxt;
	sfpe_frm_t frm_r;
	sfpe_frm_t frm_nxt;
	sfpe_core_t core_r;
	sfpe_core_t core_nxt;

	// Two page buffers; shared port, so decoder writes yield to reads
	logic [7:0] buf1_mem [0:527];
	logic [7:0] buf2_mem [0:527];
	logic mem_we;
	logic mem_sel;
	logic [9:0] mem_addr;
	logic [7:0] mem_wd;
	logic [7:0] rd_data_r;

	// Advance a buffer offset with wrap at the buffer end
	function automatic logic [9:0] sfpe_next_offs(input logic [9:0] o);
		sfpe_next_offs = (o == `SFPE_BUF_LAST) ? 10'h000 : 10'(o + 10'h001); // [R2]
	endfunction : sfpe_next_offs

	// Buffer select: second-buffer opcodes
	function automatic logic sfpe_is_b2(input logic [7:0] op);
		sfpe_is_b2 = (op == `SFPE_OP_LOAD_B2) || (op == `SFPE_OP_PGE_B2) ||
			(op == `SFPE_OP_PGN_B2) || (op == `SFPE_OP_THRU_B2) ||
			(op == `SFPE_OP_XFR_B2) || (op == `SFPE_OP_ARW_B2);
	endfunction : sfpe_is_b2

	// Opcodes whose data bytes go into a buffer
	function automatic logic sfpe_is_load(input logic [7:0] op);
		sfpe_is_load = (op == `SFPE_OP_LOAD_B1) || (op == `SFPE_OP_LOAD_B2) ||
			(op == `SFPE_OP_THRU_B1) || (op == `SFPE_OP_THRU_B2);
	endfunction : sfpe_is_load

	// Link bit and byte assembly, MSB first
	// The byte and its first-of-frame flag stay put for a whole byte time after
	// the toggle flips, which gives the core ample time to pick them up.
	always_comb begin
		lnk_nxt = lnk_r;
		frm_nxt = frm_r;
		frm_nxt.bits = 3'(frm_r.bits + 3'h1);
		if (frm_r.bits == 3'h7) begin
			// Whole byte: hand it over with a toggle
			lnk_nxt.word = {frm_r.first, lnk_r.shf, si_i}; // [R17]
			lnk_nxt.tog = ~lnk_r.tog;
			frm_nxt.first = 1'b0;
		end else begin
			lnk_nxt.shf = {lnk_r.shf[5:0], si_i}; // [R17]
		end
	end

	// Link state that survives frames; reset only by the core reset
	always_ff @(posedge sck_i or posedge rst_i) begin
		if (rst_i) begin
			lnk_r <= '0;
		end else if (!cs_n_i) begin
			lnk_r <= lnk_nxt;
		end
	end

	// Frame position restarts whenever select is high, even with sck stopped;
	// reset clears it too, since select may sit high from power-up with no edge
	always_ff @(posedge sck_i or posedge cs_n_i or posedge rst_i) begin
		if (cs_n_i || rst_i) begin
			frm_r <= '{bits: 3'h0, first: 1'b1}; // [R13]
		end else begin
			frm_r <= frm_nxt;
		end
	end

	// Core: crossing, receive buffer, command decode and timing
	always_comb begin
		logic [8:0] head;
		logic byte_ev;
		logic cs_rise;
		logic empty;
		logic full;
		logic drain;
		logic [7:0] b;
		// Every local gets a value first, so no path leaves a latch behind
		head = core_r.fifo[core_r.rp[0]];
		b = head[7:0];
		core_nxt = core_r;
		core_nxt.start = 1'b0;
		core_nxt.ovf = 1'b0;
		mem_we = 1'b0;
		mem_sel = sfpe_is_b2(core_r.opc);
		mem_addr = core_r.offs;
		mem_wd = head[7:0];
		// Synchronisers
		core_nxt.cs_s1 = cs_n_i;
		core_nxt.cs_s2 = core_r.cs_s1;
		core_nxt.cs_d = core_r.cs_s2;
		core_nxt.tg_s1 = lnk_r.tog;
		core_nxt.tg_s2 = core_r.tg_s1;
		core_nxt.tg_d = core_r.tg_s2;
		byte_ev = core_r.tg_s2 ^ core_r.tg_d;
		cs_rise = core_r.cs_s2 & ~core_r.cs_d;
		empty = (core_r.wp == core_r.rp);
		full = (core_r.wp == {~core_r.rp[1], core_r.rp[0]});
		// Fill side: the link cannot pause, so a full buffer drops the byte
		if (byte_ev) begin
			if (full) begin
				core_nxt.ovf = 1'b1;
			end else begin
				core_nxt.fifo[core_r.wp[0]] = lnk_r.word;
				core_nxt.wp = 2'(core_r.wp + 2'h1);
			end
		end
		if (cs_rise) begin
			core_nxt.end_pend = 1'b1;
		end
		// Drain side stalls while the array side reads the buffers
		drain = !empty && !rd_en_i;
		if (drain) begin
			core_nxt.rp = 2'(core_r.rp + 2'h1);
			b = head[7:0];
			if (head[8]) begin
				// Opcode byte opens a new command
				core_nxt.opc = b;
				core_nxt.idx = 3'h1;
			end else if (core_r.idx != `SFPE_DATA_IDX) begin
				// Address bytes, MSB first
				core_nxt.addr = {core_r.addr[15:0], b}; // [R17]
				core_nxt.idx = 3'(core_r.idx + 3'h1);
				core_nxt.offs = {core_r.addr[1:0], b}; // [R1] [R10]
			end else if (sfpe_is_load(core_r.opc)) begin
				// Data byte into the chosen buffer
				mem_we = 1'b1; // [R2] [R10]
				core_nxt.offs = sfpe_next_offs(core_r.offs); // [R2]
			end
		end
		// Deselect acts once every byte of the frame has been decoded
		// Bytes still inside the crossing are waited for by the byte_ev term.
		if (core_r.end_pend && empty && !byte_ev) begin
			// A second deselect landing in this very cycle must not be lost,
			// so the fresh event wins over the clear
			core_nxt.end_pend = cs_rise;
			core_nxt.idx = 3'h0;
			core_nxt.opc = 8'h00;
			core_nxt.bsel = sfpe_is_b2(core_r.opc);
			core_nxt.page = core_r.addr[`SFPE_PAGE_MSB:`SFPE_PAGE_LSB]; // [R3] [R7]
			core_nxt.blk = core_r.addr[`SFPE_PAGE_MSB:`SFPE_PAGE_LSB + `SFPE_BLK_LSB]; // [R9]
			// Short commands are dropped; busy device starts nothing
			if (core_r.idx == `SFPE_DATA_IDX && core_r.st == SFPE_ST_IDLE) begin // [R18]
				core_nxt.start = 1'b1;
				core_nxt.st = SFPE_ST_BUSY;
				case (core_r.opc)
					`SFPE_OP_PGE_B1, `SFPE_OP_PGE_B2,
					`SFPE_OP_THRU_B1, `SFPE_OP_THRU_B2: begin
						// Erase to ones, then program from buffer
						core_nxt.kind = SFPE_K_PGM_ERASE; // [R4] [R11]
						core_nxt.cnt = 32'(EP_CYC);
					end
					`SFPE_OP_PGN_B1, `SFPE_OP_PGN_B2: begin
						// Page assumed erased by the host
						core_nxt.kind = SFPE_K_PGM_ONLY; // [R5] [R6]
						core_nxt.cnt = 32'(P_CYC);
					end
					`SFPE_OP_PERASE: begin
						core_nxt.kind = SFPE_K_PAGE_ERASE; // [R7]
						core_nxt.cnt = 32'(PE_CYC);
					end
					`SFPE_OP_BERASE: begin
						core_nxt.kind = SFPE_K_BLOCK_ERASE; // [R8]
						core_nxt.cnt = 32'(BE_CYC);
					end
					`SFPE_OP_XFR_B1, `SFPE_OP_XFR_B2: begin
						core_nxt.kind = SFPE_K_COPY; // [R12]
						core_nxt.cnt = 32'(XFR_CYC);
					end
					`SFPE_OP_ARW_B1, `SFPE_OP_ARW_B2: begin
						// Copy in, then erase and program back
						core_nxt.kind = SFPE_K_REWRITE; // [R14] [R15]
						core_nxt.cnt = 32'(XFR_CYC + EP_CYC);
					end
					default: begin
						// Buffer load or unknown opcode: nothing self-timed
						core_nxt.start = 1'b0;
						core_nxt.st = SFPE_ST_IDLE;
						core_nxt.kind = SFPE_K_NONE;
					end
				endcase
			end
		end
		// Busy countdown
		// Runs for exactly the loaded number of core cycles, start cycle included.
		case (core_r.st)
			SFPE_ST_BUSY: begin
				if (core_r.cnt <= 32'h0000_0001) begin
					core_nxt.st = SFPE_ST_IDLE; // [R16]
					core_nxt.cnt = 32'h0000_0000;
				end else begin
					core_nxt.cnt = 32'(core_r.cnt - 32'h0000_0001);
				end
			end
			SFPE_ST_IDLE: begin
				// Leave the count alone: the deselect logic above may have just
				// loaded it for a new operation, and overwriting it here would
				// cut the busy period to a single cycle
			end
			default: begin
				core_nxt.st = SFPE_ST_IDLE;
			end
		endcase
	end

	// Core register. The select synchroniser resets to the idle (high) level so
	// that leaving reset never looks like a deselect; the byte toggle resets to
	// match the link side, which the same reset clears.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_r <= '0;
			core_r.cs_s1 <= 1'b1;
			core_r.cs_s2 <= 1'b1;
			core_r.cs_d <= 1'b1;
			core_r.st <= SFPE_ST_IDLE;
			core_r.kind <= SFPE_K_NONE;
		end else begin
			core_r <= core_nxt;
		end
	end

	// Buffer memories; reads registered for the array side
	// The memories have no reset: their contents are undefined until loaded,
	// so a host must load a buffer before programming a page from it.
	always_ff @(posedge clk_i) begin
		if (mem_we && !mem_sel) begin
			buf1_mem[mem_addr] <= mem_wd;
		end
		if (mem_we && mem_sel) begin
			buf2_mem[mem_addr] <= mem_wd;
		end
		if (rst_i) begin
			rd_data_r <= 8'h00;
		end else if (rd_en_i) begin
			rd_data_r <= rd_buf_i ? buf2_mem[rd_addr_i] : buf1_mem[rd_addr_i];
		end
	end

	// Outputs
	// Status carries only the ready bit; the other bits read zero
	assign rdy_o = (core_r.st == SFPE_ST_IDLE); // [R16]
	assign status_o = {(core_r.st == SFPE_ST_IDLE), 7'h00}; // [R16]
	assign op_start_o = core_r.start;
	assign op_kind_o = core_r.kind;
	assign op_buf_o = core_r.bsel;
	assign op_page_o = core_r.page;
	assign op_block_o = core_r.blk;
	assign rd_data_o = rd_data_r;
	assign ovf_o = core_r.ovf;
endmodule : sfpe_seq

// ==== sfpe_checker.sv ====
// Port-level checks for the program/erase sequencer.
// Assumes a bind to sfpe_seq that hands on the time parameters.
`include "sfpe_defs.svh"
module sfpe_checker #(
	parameter int EP_US = 1,
	parameter int P_US = 1,
	parameter int PE_US = 1,
	parameter int BE_US = 1,
	parameter int XFR_US = 1
) (
	// Core clock, reset and select
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	// Status and operation report
	input wire logic rdy_o,
	input wire logic [7:0] status_o,
	input wire logic op_start_o,
	input wire sfpe_pkg::sfpe_kind_t op_kind_o,
	input wire logic [12:0] op_page_o,
	input wire logic [9:0] op_block_o,
	// Buffer read port
	input wire logic rd_en_i,
	input wire logic [7:0] rd_data_o
);
	import sfpe_pkg::*;
	int busy_cnt_r; // Busy cycles seen since the last start
	int busy_exp; // Busy length owed by the current kind

	// Expected busy length; rewrite is copy and erase-program back to back
	always_comb begin
		case (op_kind_o)
			SFPE_K_PGM_ERASE: busy_exp = EP_US * `SFPE_CLK_MHZ;
			SFPE_K_PGM_ONLY: busy_exp = P_US * `SFPE_CLK_MHZ;
			SFPE_K_PAGE_ERASE: busy_exp = PE_US * `SFPE_CLK_MHZ;
			SFPE_K_BLOCK_ERASE: busy_exp = BE_US * `SFPE_CLK_MHZ;
			SFPE_K_COPY: busy_exp = XFR_US * `SFPE_CLK_MHZ;
			SFPE_K_REWRITE: busy_exp = (XFR_US + EP_US) * `SFPE_CLK_MHZ;
			default: busy_exp = 0;
		endcase
	end

	// Counter, since a busy period is far longer than a repetition may be
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_cnt_r <= 0;
		end else if (op_start_o) begin
			busy_cnt_r <= 1;
		end else if (!rdy_o) begin
			busy_cnt_r <= busy_cnt_r + 1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_status; status_o == {rdy_o, 7'h00}; endproperty
	a_status: assert property (p_status) else $error("status byte disagrees with ready");
	property p_block; op_block_o == op_page_o[12:3]; endproperty
	a_block: assert property (p_block) else $error("block is not page bits 12 to 3");
	property p_busy_len; $rose(rdy_o) |-> busy_cnt_r == busy_exp; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy period has wrong length");
	property p_start_busy; op_start_o |-> !rdy_o; endproperty
	a_start_busy: assert property (p_start_busy) else $error("start without busy");
	property p_fall_start; $fell(rdy_o) |-> op_start_o; endproperty
	a_fall_start: assert property (p_fall_start) else $error("busy without a start");
	property p_start_idle; op_start_o |-> $past(rdy_o); endproperty
	a_start_idle: assert property (p_start_idle) else $error("start while still busy");
	property p_start_desel; op_start_o |-> cs_n_i && $past(cs_n_i, 2); endproperty
	a_start_desel: assert property (p_start_desel) else $error("start before deselect");
	property p_rd_hold; !rd_en_i |=> $stable(rd_data_o); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved unasked");
endmodule : sfpe_checker

// ==== sfpe_host.sv ====
// Host-side serial master model: select, serial clock and data.
// Assumes the bench fills q before calling run.
module sfpe_host (
	// Serial link pins
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] q[$]; // Frame bytes, opcode first

	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end

	// Shifts nbits of q; clock runs only inside the frame, 30 ns period
	task automatic run(input int nbits);
		cs_n_o = 1'b0;
		#20;
		for (int i = 0; i < nbits; i++) begin
			si_o = q[i / 8][7 - i % 8];
			#15 sck_o = 1'b1;
			#15 sck_o = 1'b0;
		end
		#40 cs_n_o = 1'b1;
		si_o = ~si_o; // Released line must not keep the last bit
	endtask : run
endmodule : sfpe_host

// ==== serial_flash_program_erase_cmds_tb_top.sv ====
// Self-checking bench for the sequencer, with a behavioural buffer model.
// Assumes sfpe_host drives the link and sfpe_checker is bound below.
module serial_flash_program_erase_cmds_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import sfpe_pkg::*;
	// Reset starts low and is raised at time zero, so the link side sees an edge
	logic clk_i = 0, rst_i = 0, rd_en_i = 0, rd_buf_i = 0;
	logic [9:0] rd_addr_i = 0;
	wire sck, cs_n, si;
	logic rdy_o, op_start_o, op_buf_o, ovf_o;
	logic [7:0] status_o, rd_data_o;
	sfpe_kind_t op_kind_o;
	logic [12:0] op_page_o, pg;
	logic [9:0] op_block_o;
	int n_fail = 0, samples_checked = 0, seed = 32'hd6f7be34, off, st_w, n_ovf = 0;
	int bm[2][528]; // Buffer model
	// Opcodes with kind and buffer; each program-only follows an erase of its page
	logic [7:0] ops[12] = '{8'h83, 8'h86, 8'h81, 8'h88, 8'h50, 8'h89, 8'h82, 8'h85,
		8'h53, 8'h55, 8'h58, 8'h59};
	int kinds[12] = '{1, 1, 3, 2, 4, 2, 1, 1, 5, 5, 6, 6};
	logic bufs[12] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

	sfpe_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si));
	sfpe_seq #(.EP_US(1), .P_US(1), .PE_US(1), .BE_US(1), .XFR_US(1)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
		.rdy_o(rdy_o), .status_o(status_o), .op_start_o(op_start_o), .op_kind_o(op_kind_o),
		.op_buf_o(op_buf_o), .op_page_o(op_page_o), .op_block_o(op_block_o),
		.rd_en_i(rd_en_i), .rd_buf_i(rd_buf_i), .rd_addr_i(rd_addr_i),
		.rd_data_o(rd_data_o), .ovf_o(ovf_o));

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask : chk

	task automatic conclude;
		if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// Any dropped byte is a fault here: the array side never stalls mid-frame
	always @(posedge clk_i) begin
		if (ovf_o === 1'b1) n_ovf++;
	end

	// Frame of opcode, address and nd random data bytes; model follows loads
	task automatic send(input logic [7:0] op, input logic [23:0] a, input int nd, input int nb);
		logic [7:0] d;
		host.q = '{op, a[23:16], a[15:8], a[7:0]};
		off = a[9:0];
		repeat (nd) begin
			d = 8'($random(seed));
			host.q.push_back(d);
			bm[op == 8'h87 || op == 8'h85][off] = d;
			off = (off == 527) ? 0 : off + 1;
		end
		host.run(nb);
		// Catch the one-cycle start pulse; a frame that starts nothing waits it out
		st_w = 0;
		while (op_start_o !== 1'b1 && st_w < 20) begin
			@(posedge clk_i);
			#1 if (op_start_o !== 1'b1) st_w++;
		end
	endtask : send

	task automatic rd_chk(input logic b, input int a);
		@(posedge clk_i);
		rd_en_i <= 1'b1;
		rd_buf_i <= b;
		rd_addr_i <= 10'(a);
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1 chk(rd_data_o, 32'(bm[b][a]));
	endtask : rd_chk

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	initial begin
		repeat (60000) @(posedge clk_i);
		chk(0, 1);
		conclude();
	end

	initial begin
		logic [23:0] a;
		int w;
		// Raised by a scheduled update so the link side's reset sees an edge
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1 chk(status_o, 8'h80);
		// A load across the buffer end, then one into the second buffer, ignored bits random; loads start nothing
		send(8'h84, {14'($random(seed)), 10'd526}, 4, 64);
		chk(st_w, 20);
		send(8'h87, {14'($random(seed)), 10'd5}, 2, 48);
		chk(st_w, 20);
		for (int i = 0; i < 4; i++) rd_chk(0, (526 + i) % 528);
		rd_chk(1, 5);
		rd_chk(1, 6);
		// Cut frames start nothing
		for (int nb = 24; nb <= 31; nb += 7) begin
			send(8'h83, 24'h000000, 0, nb);
			chk(st_w, 20);
			chk(rdy_o, 1);
		end
		pg = 13'($random(seed));
		for (int i = 0; i < 12; i++) begin
			a = {1'($random(seed)), pg, 10'({$random(seed)} % 528)};
			send(ops[i], a, (ops[i] == 8'h82 || ops[i] == 8'h85) ? 2 : 0,
				(ops[i] == 8'h82 || ops[i] == 8'h85) ? 48 : 32);
			chk(st_w < 20, 1);
			chk(status_o, 8'h00);
			chk(op_kind_o, kinds[i]);
			chk(op_page_o, pg);
			chk(op_block_o, pg[12:3]);
			if (ops[i] != 8'h81 && ops[i] != 8'h50) chk(op_buf_o, bufs[i]);
			w = 1;
			while (rdy_o !== 1'b1 && w < 100) begin
				@(posedge clk_i);
				#1 if (rdy_o !== 1'b1) w++;
			end
			chk(w, kinds[i] == 6 ? 40 : 20);
			if (ops[i] == 8'h82 || ops[i] == 8'h85) rd_chk(bufs[i], a[9:0]);
			repeat (12) @(posedge clk_i);
		end
		chk(n_ovf, 0);
		conclude();
	end
endmodule : serial_flash_program_erase_cmds_tb_top

bind sfpe_seq sfpe_checker #(.EP_US(EP_US), .P_US(P_US), .PE_US(PE_US), .BE_US(BE_US),
	.XFR_US(XFR_US)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .rdy_o(rdy_o),
	.status_o(status_o), .op_start_o(op_start_o), .op_kind_o(op_kind_o),
	.op_page_o(op_page_o), .op_block_o(op_block_o), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o));
